// [design/ltc_defs.svh]
// Constants for the timebase and capture timer: register offsets, field positions, timing counts.
`ifndef LTC_DEFS_SVH
`define LTC_DEFS_SVH

`define LTC_ADDR_W 3
`define LTC_OFS_B1CS 3'h0
`define LTC_OFS_CAP 3'h1
`define LTC_OFS_CAP_ALIAS 3'h2
`define LTC_OFS_B2CNT 3'h3
`define LTC_OFS_B2RLD 3'h4
`define LTC_OFS_B2CS 3'h5
`define LTC_OFS_IRQ_ST 3'h6
`define LTC_OFS_IRQ_MASK 3'h7

`define LTC_B1CS_IE 0
`define LTC_B1CS_DBL 1
`define LTC_B1CS_CIE 2
`define LTC_B1CS_CF 3
`define LTC_B1CS_F 4
`define LTC_B2CS_IE 0
`define LTC_B2CS_F 1

`define LTC_ST_B1 0
`define LTC_ST_CAP 1
`define LTC_ST_B2 2
`define LTC_ST_W 3

`define LTC_PRESCALE 32
`define LTC_C1_TOP 8'hF9
`define LTC_C2_TOP 8'hFF
`define LTC_ZERO8 8'h00
`define LTC_RLD_RESET 8'h00

`endif

// [design/ltc_pkg.sv]
// Types shared by the timebase and capture timer files.
`include "ltc_defs.svh"
package ltc_pkg;
    typedef struct packed {
        logic [`LTC_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ltc_bus_req_t;

    typedef enum logic [1:0] {
        LTC_CAP_ARMED = 2'b01,
        LTC_CAP_HELD = 2'b10
    } ltc_cap_state_t;
endpackage : ltc_pkg

// [design/ltc_sync.sv]
// Two flip-flop synchroniser for the capture input pin.
`timescale 1ns/1ps
`default_nettype none
module ltc_sync (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_async,
    output logic o_sync
);
    logic meta;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            meta <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule : ltc_sync
`default_nettype wire

// [design/ltc_prescaler.sv]
// Divider that emits a one-cycle tick every DIV clocks.
`timescale 1ns/1ps
`default_nettype none
`include "ltc_defs.svh"
module ltc_prescaler #(
    parameter int DIV = `LTC_PRESCALE
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    output logic o_tick
);
    localparam int W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    logic [W-1:0] cnt;
    wire at_last = (cnt == LAST);
    wire [W-1:0] next_cnt = at_last ? '0 : cnt + 1'b1;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            cnt <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            o_tick <= at_last;
        end
    end
endmodule : ltc_prescaler
`default_nettype wire

// [design/ltc_timer.sv]
// Timebase and capture timer: two 8-bit timebase counters, input capture, registers, interrupt.
// Behaviour
// RQ1 - Counter 1 starts at zero, steps every 32 clocks.
// RQ2 - Counter 1 wraps F9h to 00h with overflow.
// RQ3 - Doubling bit makes overflow interval twice as long.
// RQ4 - Counter 1 overflow sets flag; interrupt when enabled.
// RQ5 - Reading base-1 control/status clears its flag.
// RQ6 - Capture pin edge copies counter 1 value.
// RQ7 - Capture sets capture flag; interrupt when enabled.
// RQ8 - Reading capture register clears capture flag.
// RQ9 - Captures ignored while flag set; value held.
// RQ10 - Counter 2 readable, starts at reload, steps.
// RQ11 - Counter 2 at FFh reloads and signals overflow.
// RQ12 - New reload value applies only at next overflow.
// RQ13 - Counter 2 overflow sets flag; interrupt when enabled.
// RQ14 - Reading base-2 control/status clears its flag.
// RQ15 - Setting a flag beats a simultaneous clearing read.
// RQ16 - Capture pin synchronised; interrupts level while enabled.
`timescale 1ns/1ps
`default_nettype none
`include "ltc_defs.svh"
module ltc_timer #(
    parameter int PRESCALE = `LTC_PRESCALE
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire ltc_pkg::ltc_bus_req_t i_bus,
    output logic [7:0] o_rdata,
    input wire logic i_capture_input_pin,
    output logic o_base1_irq,
    output logic o_capture_irq,
    output logic o_base2_irq,
    output logic o_irq
);
    import ltc_pkg::*;

    logic tick;
    logic cap_pin_sync;
    logic cap_pin_prev;
    logic [7:0] count1;
    logic dbl_phase;
    logic [7:0] count2;
    logic [7:0] base2_reload_value;
    logic [7:0] capture_value;
    logic base1_overflow_flag;
    logic base1_irq_enable;
    logic timebase_double_sel;
    logic capture_flag;
    logic capture_irq_enable;
    logic base2_overflow_flag;
    logic base2_irq_enable;
    logic [`LTC_ST_W-1:0] irq_status;
    logic [`LTC_ST_W-1:0] irq_mask;
    ltc_cap_state_t cap_state;
    ltc_cap_state_t next_cap_state;

    ltc_prescaler #(
        .DIV(PRESCALE)
    ) u_prescaler (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .o_tick(tick)
    );

    ltc_sync u_cap_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_capture_input_pin),
        .o_sync(cap_pin_sync)
    );

    // Register decode.
    wire wr_b1cs = i_bus.wr && (i_bus.addr == `LTC_OFS_B1CS);
    wire wr_b2rld = i_bus.wr && (i_bus.addr == `LTC_OFS_B2RLD);
    wire wr_b2cs = i_bus.wr && (i_bus.addr == `LTC_OFS_B2CS);
    wire wr_mask = i_bus.wr && (i_bus.addr == `LTC_OFS_IRQ_MASK);
    wire rd_b1cs = i_bus.rd && (i_bus.addr == `LTC_OFS_B1CS);
    wire rd_cap = i_bus.rd && ((i_bus.addr == `LTC_OFS_CAP) ||
                               (i_bus.addr == `LTC_OFS_CAP_ALIAS));
    wire rd_b2cs = i_bus.rd && (i_bus.addr == `LTC_OFS_B2CS);
    wire rd_st = i_bus.rd && (i_bus.addr == `LTC_OFS_IRQ_ST);

    // Counter 1: with doubling, only every second wrap counts as an overflow.
    wire c1_wrap = tick && (count1 == `LTC_C1_TOP); // [RQ2]
    wire [7:0] next_count1 = c1_wrap ? `LTC_ZERO8 : (tick ? count1 + 8'h01 : count1); // [RQ1]
    wire c1_ovf = c1_wrap && (!timebase_double_sel || dbl_phase); // [RQ3]
    wire next_dbl_phase = c1_wrap ? (timebase_double_sel && !dbl_phase) : dbl_phase;

    // Counter 2 reloads from the reload register only on overflow.
    wire c2_ovf = tick && (count2 == `LTC_C2_TOP); // [RQ11]
    wire [7:0] next_count2 = c2_ovf ? base2_reload_value :
                             (tick ? count2 + 8'h01 : count2); // [RQ12]

    // Capture: edge on the synchronised pin, taken only while armed.
    wire cap_edge = cap_pin_sync ^ cap_pin_prev; // [RQ16]
    wire cap_take = cap_edge && (cap_state == LTC_CAP_ARMED); // [RQ9]

    always_comb begin
        next_cap_state = cap_state;
        case (cap_state)
            LTC_CAP_ARMED: begin
                if (cap_take) begin
                    next_cap_state = LTC_CAP_HELD;
                end
            end
            LTC_CAP_HELD: begin
                if (rd_cap) begin
                    next_cap_state = LTC_CAP_ARMED; // [RQ8]
                end
            end
            default: begin
                next_cap_state = LTC_CAP_ARMED;
            end
        endcase
    end

    // Flags: a set in the same cycle as a clearing read wins.
    wire next_b1f = c1_ovf || (base1_overflow_flag && !rd_b1cs); // [RQ4] [RQ5] [RQ15]
    wire next_cf = cap_take || (capture_flag && !rd_cap); // [RQ7] [RQ8] [RQ15]
    wire next_b2f = c2_ovf || (base2_overflow_flag && !rd_b2cs); // [RQ13] [RQ14] [RQ15]
    wire [`LTC_ST_W-1:0] ev = {c2_ovf, cap_take, c1_ovf};
    wire [`LTC_ST_W-1:0] next_irq_status = ev | (rd_st ? '0 : irq_status);

    wire [7:0] b1cs_view = {3'b000, base1_overflow_flag, capture_flag, capture_irq_enable,
                            timebase_double_sel, base1_irq_enable};
    wire [7:0] b2cs_view = {6'b00_0000, base2_overflow_flag, base2_irq_enable};
    wire [7:0] rd_mux =
        (i_bus.addr == `LTC_OFS_B1CS) ? b1cs_view :
        (i_bus.addr == `LTC_OFS_CAP) ? capture_value :
        (i_bus.addr == `LTC_OFS_CAP_ALIAS) ? capture_value :
        (i_bus.addr == `LTC_OFS_B2CNT) ? count2 : // [RQ10]
        (i_bus.addr == `LTC_OFS_B2RLD) ? base2_reload_value :
        (i_bus.addr == `LTC_OFS_B2CS) ? b2cs_view :
        (i_bus.addr == `LTC_OFS_IRQ_ST) ? {5'b0_0000, irq_status} :
        {5'b0_0000, irq_mask};

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            count1 <= `LTC_ZERO8; // [RQ1]
            dbl_phase <= 1'b0;
            count2 <= `LTC_RLD_RESET; // [RQ10]
            cap_pin_prev <= 1'b0;
            cap_state <= LTC_CAP_ARMED;
        end else begin
            count1 <= next_count1;
            dbl_phase <= next_dbl_phase;
            count2 <= next_count2;
            cap_pin_prev <= cap_pin_sync;
            cap_state <= next_cap_state;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            capture_value <= `LTC_ZERO8;
        end else if (cap_take) begin
            capture_value <= count1; // [RQ6]
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            base1_overflow_flag <= 1'b0;
            capture_flag <= 1'b0;
            base2_overflow_flag <= 1'b0;
            irq_status <= '0;
        end else begin
            base1_overflow_flag <= next_b1f;
            capture_flag <= next_cf;
            base2_overflow_flag <= next_b2f;
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            base1_irq_enable <= 1'b0;
            timebase_double_sel <= 1'b0;
            capture_irq_enable <= 1'b0;
            base2_irq_enable <= 1'b0;
            base2_reload_value <= `LTC_RLD_RESET;
            irq_mask <= '0;
        end else begin
            if (wr_b1cs) begin
                base1_irq_enable <= i_bus.wdata[`LTC_B1CS_IE];
                timebase_double_sel <= i_bus.wdata[`LTC_B1CS_DBL];
                capture_irq_enable <= i_bus.wdata[`LTC_B1CS_CIE];
            end
            if (wr_b2cs) begin
                base2_irq_enable <= i_bus.wdata[`LTC_B2CS_IE];
            end
            if (wr_b2rld) begin
                base2_reload_value <= i_bus.wdata; // [RQ12]
            end
            if (wr_mask) begin
                irq_mask <= i_bus.wdata[`LTC_ST_W-1:0];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_rdata <= `LTC_ZERO8;
        end else begin
            o_rdata <= i_bus.rd ? rd_mux : `LTC_ZERO8;
        end
    end

    assign o_base1_irq = base1_overflow_flag && base1_irq_enable; // [RQ4] [RQ16]
    assign o_capture_irq = capture_flag && capture_irq_enable; // [RQ7] [RQ16]
    assign o_base2_irq = base2_overflow_flag && base2_irq_enable; // [RQ13] [RQ16]
    assign o_irq = |(irq_status & irq_mask);
endmodule : ltc_timer
`default_nettype wire

// [bench/ltc_pin_src.sv]
// Far-side source that moves the capture pin after each request.
`timescale 1ns/1ps
`default_nettype none
module ltc_pin_src (
    input wire logic i_toggle,
    output logic o_pin
);
    initial o_pin = 1'b0;
    // The pin moves off the clock grid, as an outside signal would.
    always @(posedge i_toggle) #1.3 o_pin = ~o_pin;
endmodule : ltc_pin_src
`default_nettype wire

// [bench/ltc_timer_assertions.sv]
// Concurrent checks on the timer ports.
`timescale 1ns/1ps
`default_nettype none
module ltc_timer_assertions #(
    parameter int PRESCALE = 32
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire ltc_pkg::ltc_bus_req_t i_bus,
    input wire logic [7:0] o_rdata,
    input wire logic i_capture_input_pin,
    input wire logic o_base1_irq,
    input wire logic o_capture_irq,
    input wire logic o_base2_irq,
    input wire logic o_irq
);
    import ltc_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic r = i_bus.rd;
    wire logic w = i_bus.wr;
    wire logic [2:0] a = i_bus.addr;
    sequence s_rd(logic [2:0] x);
        r && a == x;
    endsequence
    property p_idle;
        !$past(r) |-> o_rdata == 8'h00;
    endproperty
    property p_b1_fall;
        $fell(o_base1_irq) |-> $past((r || w) && a == 3'h0);
    endproperty
    property p_cap_fall;
        $fell(o_capture_irq) |-> $past(r && a inside {3'h1, 3'h2} || w && a == 3'h0);
    endproperty
    property p_b2_fall;
        $fell(o_base2_irq) |-> $past((r || w) && a == 3'h5);
    endproperty
    property p_irq_fall;
        $fell(o_irq) |-> $past(r && a == 3'h6 || w && a == 3'h7);
    endproperty
    property p_b1_rd;
        s_rd(3'h0) ##0 o_base1_irq |=> o_rdata[4] && o_rdata[0];
    endproperty
    property p_cap_rd;
        s_rd(3'h0) ##0 o_capture_irq |=> o_rdata[3] && o_rdata[2];
    endproperty
    property p_b2_rd;
        s_rd(3'h5) ##0 o_base2_irq |=> o_rdata == 8'h03;
    endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    a_b1_fall: assert property (p_b1_fall) else $error("b1 irq fell");
    a_cap_fall: assert property (p_cap_fall) else $error("cap irq fell");
    a_b2_fall: assert property (p_b2_fall) else $error("b2 irq fell");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
    a_b1_rd: assert property (p_b1_rd) else $error("b1 flag read");
    a_cap_rd: assert property (p_cap_rd) else $error("cap flag read");
    a_b2_rd: assert property (p_b2_rd) else $error("b2 flag read");
endmodule : ltc_timer_assertions
bind ltc_timer ltc_timer_assertions #(.PRESCALE(PRESCALE)) u_chk (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_capture_input_pin(i_capture_input_pin), .o_base1_irq(o_base1_irq),
    .o_capture_irq(o_capture_irq), .o_base2_irq(o_base2_irq), .o_irq(o_irq));
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the timer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ltc_pkg::*;
    localparam int PS = 4;
    logic clk;
    logic rst_n;
    ltc_bus_req_t bus;
    logic tog;
    wire logic pin;
    logic [7:0] rdata;
    logic b1, cap, b2, irq;
    int errors;
    int comparisons;
    int n;
    logic [19:0] rows [6];
    logic [7:0] v, v1;
    ltc_timer #(.PRESCALE(PS)) dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_bus(bus),
        .o_rdata(rdata), .i_capture_input_pin(pin), .o_base1_irq(b1),
        .o_capture_irq(cap), .o_base2_irq(b2), .o_irq(irq));
    ltc_pin_src src (.i_toggle(tog), .o_pin(pin));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic close_out;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic meas(input int s, output int t);
        t = 0;
        while ((({b2, cap, b1} >> s) & 3'h1) !== 3'h1) begin
            @(posedge clk);
            #1 t++;
            if (t > 2500) begin
                errors++;
                close_out();
            end
        end
    endtask : meas
    // Clears a flag by its read, then counts cycles to the next rise.
    task automatic itv(input int s, input logic [2:0] a, output int t);
        rd(a, v);
        meas(s, t);
        t = t + 2;
    endtask : itv
    task automatic pulse;
        @(posedge clk);
        tog <= 1'b1;
        @(posedge clk);
        tog <= 1'b0;
    endtask : pulse
    initial begin
        rows = '{{1'b0, 3'h4, 8'h00, 8'h00}, {1'b1, 3'h4, 8'h5A, 8'h5A},
            {1'b1, 3'h7, 8'h07, 8'h07}, {1'b1, 3'h5, 8'h01, 8'h01},
            {1'b1, 3'h1, 8'hAA, 8'h00}, {1'b1, 3'h0, 8'h05, 8'h05}};
        errors = 0;
        comparisons = 0;
        bus = '0;
        tog = 1'b0;
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i][19]) wr(rows[i][18:16], rows[i][15:8]);
            rd(rows[i][18:16], v);
            chk(v, rows[i][7:0]);
        end
        $display("test registers done");
        rd(3'h3, v);
        chk(v < 8'h5A, 1);
        itv(2, 3'h5, n);
        rd(3'h3, v);
        chk(v == 8'h5A || v == 8'h5B, 1);
        rd(3'h5, v);
        chk(v, 8'h03);
        chk(b2, 0);
        meas(2, n);
        chk(n + 4, 166 * PS);
        $display("test counter 2 done");
        itv(0, 3'h0, n);
        itv(0, 3'h0, n);
        chk(n, 250 * PS);
        rd(3'h6, v);
        chk(v & 8'hF9, 8'h01);
        wr(3'h0, 8'h07);
        itv(0, 3'h0, n);
        itv(0, 3'h0, n);
        chk(n, 500 * PS);
        $display("test counter 1 done");
        pulse();
        meas(1, n);
        chk(n < 8, 1);
        repeat (40) @(posedge clk);
        pulse();
        repeat (10) @(posedge clk);
        rd(3'h1, v1);
        chk(cap, 0);
        rd(3'h2, v);
        chk(v, v1);
        repeat (40) @(posedge clk);
        pulse();
        meas(1, n);
        rd(3'h2, v);
        chk(v != v1, 1);
        $display("test capture done");
        wr(3'h4, 8'h33);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(3'h3, v);
        chk(v, 8'h00);
        rd(3'h4, v);
        chk(v, 8'h00);
        rd(3'h5, v);
        chk({v, irq}, 9'h000);
        $display("test reset done");
        close_out();
    end
endmodule : testbench
`default_nettype wire
